// File: design/ttcu_sync.v
/*
  Two-flop synchroniser for one asynchronous level.
  Assumes clk is the processor clock and rst_n is already synchronised.
*/
`timescale 1ns/1ps
module ttcu_sync (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Level
  input wire din,
  output wire dout
);
  reg s1_q;
  reg s2_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end

  assign dout = s2_q;
endmodule

// File: design/ttcu_top.v
/*
  Triple 16-bit timer with one shared counter element and an AHB-Lite
  register slave. Assumes a single AHB-Lite master on MCLK, word accesses,
  timer input pins asynchronous to MCLK.
*/
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "ttcu_map.vh"
module ttcu_top #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire MCLK,
  input wire RSTN,
  // AHB-Lite slave
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  // Timer pins
  input wire TMR_IN0,
  input wire TMR_IN1,
  output reg TMR_OUT0,
  output reg TMR_OUT1,
  // Timer interrupt requests, one per timer
  output reg [2:0] TMR_IRQ
);
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n;

  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Input pins, synchronised, then latched edges
  wire [1:0] pin_s;
  reg [1:0] pin_prev_q;
  reg [1:0] pin_rise_q;
  ttcu_sync u_sync0 (.clk(MCLK), .rst_n(rst_n), .din(TMR_IN0),
    .dout(pin_s[0]));
  ttcu_sync u_sync1 (.clk(MCLK), .rst_n(rst_n), .din(TMR_IN1),
    .dout(pin_s[1]));

  // Register banks
  reg [WIDTH-1:0] cnt_q [0:2];
  reg [WIDTH-1:0] cmpa_q [0:2];
  reg [WIDTH-1:0] cmpb_q [0:1];
  reg [15:0] ctl_q [0:2];
  reg [1:0] slot_q;
  reg t2_max_q;

  // AHB address phase capture
  reg wr_pend_q;
  reg [7:0] addr_q;
  wire acc = HSEL & HREADY & HTRANS[1];

  // Service of the slot's timer
  wire [1:0] s = slot_q;
  wire srv = (slot_q != `TTCU_SLOT_IDLE);
  wire [15:0] c = ctl_q[s];
  wire [WIDTH-1:0] cur = cnt_q[s];
  wire use_b = (s != 2'd2) & c[`TTCU_B_SEL];
  wire [WIDTH-1:0] cmp = use_b ? cmpb_q[s[0]] : cmpa_q[s];
  // Idle slot gated out so its empty bank never reaches the pin logic
  wire has_pin = srv & (s != 2'd2);
  wire external_clock_select = has_pin & c[`TTCU_B_EXT];
  wire rise = has_pin & pin_rise_q[s[0]];
  wire lvl = has_pin ? pin_s[s[0]] : 1'b1;
  wire retrig = has_pin & ~external_clock_select & c[`TTCU_B_RTG] & rise;
  reg tick;
  always @* begin
    if (external_clock_select) begin
      tick = rise;
    end else if (has_pin & c[`TTCU_B_PRE]) begin
      tick = t2_max_q;
    end else if (has_pin & ~c[`TTCU_B_RTG]) begin
      tick = lvl;
    end else begin
      tick = 1'b1;
    end
  end
  wire [WIDTH-1:0] inc = cur + {{(WIDTH-1){1'b0}}, 1'b1};
  wire go = srv & c[`TTCU_B_EN] & tick & ~retrig;
  wire hit = go & (inc == cmp);
  wire dual = has_pin & c[`TTCU_B_DUAL];

  // Write decoding of data phase
  wire [1:0] wt = addr_q[5:4];
  wire [1:0] wr = addr_q[3:2];
  wire wr_ok = wr_pend_q & (wt != 2'd3);

  integer i;
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 3; i = i + 1) begin
        cnt_q[i] <= `TTCU_CNT_RST;
        cmpa_q[i] <= `TTCU_CNT_RST;
        ctl_q[i] <= `TTCU_CTL_RST;
      end
      cmpb_q[0] <= `TTCU_CNT_RST;
      cmpb_q[1] <= `TTCU_CNT_RST;
      slot_q <= 2'd0;
      t2_max_q <= 1'b0;
      pin_prev_q <= 2'b00;
      pin_rise_q <= 2'b00;
      TMR_OUT0 <= 1'b1;
      TMR_OUT1 <= 1'b1;
      TMR_IRQ <= 3'b000;
    end else begin
      slot_q <= slot_q + 2'd1;
      pin_prev_q <= pin_s;
      // Edge held until its timer is serviced
      pin_rise_q <= pin_rise_q | (pin_s & ~pin_prev_q);
      if (srv & has_pin) begin
        pin_rise_q[s[0]] <= pin_s[s[0]] & ~pin_prev_q[s[0]];
      end
      TMR_IRQ <= 3'b000;
      if (srv & (s == 2'd0)) begin
        TMR_OUT0 <= 1'b1;
      end
      if (srv & (s == 2'd1)) begin
        TMR_OUT1 <= 1'b1;
      end
      // CPU write first; counter update below wins on shared fields
      if (wr_ok) begin
        case (wr)
          2'd0: cnt_q[wt] <= HWDATA[WIDTH-1:0];
          2'd1: cmpa_q[wt] <= HWDATA[WIDTH-1:0];
          2'd2: begin
            if (wt != 2'd2) begin
              cmpb_q[wt[0]] <= HWDATA[WIDTH-1:0];
            end
          end
          default: begin
            ctl_q[wt][`TTCU_B_MAX:0] <= HWDATA[`TTCU_B_MAX:0];
            ctl_q[wt][`TTCU_B_INTEN] <= HWDATA[`TTCU_B_INTEN];
            if (HWDATA[`TTCU_B_QUAL]) begin
              ctl_q[wt][`TTCU_B_EN] <= HWDATA[`TTCU_B_EN];
            end
          end
        endcase
      end
      if (srv) begin
        t2_max_q <= (s == 2'd2) ? hit : t2_max_q;
      end
      if (retrig) begin
        cnt_q[s] <= `TTCU_CNT_RST;
      end else if (go) begin
        cnt_q[s] <= hit ? `TTCU_CNT_RST : inc;
      end
      if (hit) begin
        ctl_q[s][`TTCU_B_MAX] <= 1'b1;
        if (c[`TTCU_B_INTEN]) begin
          TMR_IRQ[s] <= 1'b1;
        end
        if (dual) begin
          ctl_q[s][`TTCU_B_SEL] <= ~c[`TTCU_B_SEL];
        end else begin
          ctl_q[s][`TTCU_B_SEL] <= 1'b0;
        end
        // One-shot stops after a full cycle (dual: after B)
        if (~c[`TTCU_B_CONTINUOUS_RUN] & (~dual | c[`TTCU_B_SEL])) begin
          ctl_q[s][`TTCU_B_EN] <= 1'b0;
        end
        if (s == 2'd0) begin
          TMR_OUT0 <= dual ? c[`TTCU_B_SEL] : 1'b0;
        end
        if (s == 2'd1) begin
          TMR_OUT1 <= dual ? c[`TTCU_B_SEL] : 1'b0;
        end
      end else if (dual & srv) begin
        // Wave: low while B is active
        if (s == 2'd0) begin
          TMR_OUT0 <= ~c[`TTCU_B_SEL];
        end
        if (s == 2'd1) begin
          TMR_OUT1 <= ~c[`TTCU_B_SEL];
        end
      end
    end
  end

  // Read views per bank; qualifier is never stored, so it reads zero
  wire [31:0] cnt_rd [0:2];
  wire [31:0] cmpa_rd [0:2];
  wire [31:0] ctl_rd [0:2];
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_rd
      assign cnt_rd[k] = {{(32-WIDTH){1'b0}}, cnt_q[k]};
      assign cmpa_rd[k] = {{(32-WIDTH){1'b0}}, cmpa_q[k]};
      assign ctl_rd[k] = {16'h0000,
        ctl_q[k] & ~(16'h0001 << `TTCU_B_QUAL)};
    end
  endgenerate

  // AHB-Lite: zero wait states, always OKAY
  reg [31:0] rd_d;
  wire [1:0] at = HADDR[5:4];
  wire [1:0] ar = HADDR[3:2];
  always @* begin
    rd_d = 32'h0000_0000;
    if (HADDR[7:0] == `TTCU_IRQ) begin
      rd_d = {29'h0000_0000, TMR_IRQ};
    end else if (at != 2'd3) begin
      case (ar)
        2'd0: rd_d = cnt_rd[at];
        2'd1: rd_d = cmpa_rd[at];
        2'd2: rd_d[WIDTH-1:0] = (at == 2'd2) ? {WIDTH{1'b0}} :
                                cmpb_q[at[0]];
        default: rd_d = ctl_rd[at];
      endcase
    end
  end

  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      wr_pend_q <= acc & HWRITE;
      addr_q <= HADDR[7:0];
      if (acc & ~HWRITE) begin
        HRDATA <= rd_d;
      end
    end
  end
endmodule

// File: pkg/ttcu_map.vh
/*
  Register map, field positions and reset values of the triple timer unit.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef TTCU_MAP_VH
`define TTCU_MAP_VH
// Byte offsets, one aligned word per register
`define TTCU_CNT0 8'h00
`define TTCU_CMPA0 8'h04
`define TTCU_CMPB0 8'h08
`define TTCU_CTL0 8'h0C
`define TTCU_CNT1 8'h10
`define TTCU_CMPA1 8'h14
`define TTCU_CMPB1 8'h18
`define TTCU_CTL1 8'h1C
`define TTCU_CNT2 8'h20
`define TTCU_CMPA2 8'h24
`define TTCU_CTL2 8'h2C
`define TTCU_IRQ 8'h30
// Control field positions
`define TTCU_B_CONTINUOUS_RUN 0
`define TTCU_B_DUAL 1
`define TTCU_B_EXT 2
`define TTCU_B_PRE 3
`define TTCU_B_RTG 4
`define TTCU_B_MAX 5
`define TTCU_B_SEL 12
`define TTCU_B_INTEN 13
`define TTCU_B_QUAL 14
`define TTCU_B_EN 15
`define TTCU_CTL_RST 16'h0000
`define TTCU_CNT_RST 16'h0000
// Service slot codes: three timers then one idle clock
`define TTCU_SLOT_IDLE 2'h3
`endif

// File: sim/tb_top.sv
/*
  Self-checking bench for the triple timer unit over AHB-Lite.
  Assumes a zero-wait slave and the pin model beside it.
*/
`timescale 1ns/1ps
`include "ttcu_map.vh"
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] r;
  logic [31:0] v;
  wire [31:0] hrdata;
  wire hready;
  wire in0;
  wire in1;
  wire out0;
  wire out1;
  wire [2:0] irq;
  int mismatches = 0;
  int checks_done = 0;
  int w;
  always #4 clk = ~clk;
  ttcu_top DUT (.MCLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(),
    .TMR_IN0(in0), .TMR_IN1(in1), .TMR_OUT0(out0), .TMR_OUT1(out1),
    .TMR_IRQ(irq));
  ttcu_pins pins (.clk(clk), .in0(in0), .in1(in1));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(r, e);
  endtask
  // Bounded waits so a dead timer cannot hang the run
  task automatic wait_irq(input int i);
    w = 0;
    while (irq[i] !== 1'b1 && w < 100) begin
      @(posedge clk);
      w++;
    end
    chk(w < 100, 1);
  endtask
  task automatic span(input logic lv);
    w = 0;
    while (out0 === lv && w < 100) begin
      @(posedge clk);
      w++;
    end
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`TTCU_CTL0, 32'h0000_0000);
    rd(8'h3C, 32'h0000_0000);
    bus(1'b1, `TTCU_CTL0, 32'h0000_8001);
    rd(`TTCU_CTL0, 32'h0000_0001);
    bus(1'b1, `TTCU_CMPA2, 32'h0000_0003);
    bus(1'b1, `TTCU_CTL2, 32'h0000_E000);
    wait_irq(2);
    repeat (8) @(posedge clk);
    rd(`TTCU_CTL2, 32'h0000_2020);
    rd(`TTCU_CNT2, 32'h0000_0000);
    bus(1'b1, `TTCU_CTL2, 32'h0000_2000);
    rd(`TTCU_CTL2, 32'h0000_2000);
    pins.gate0(1'b1);
    bus(1'b1, `TTCU_CMPA0, 32'h0000_0001);
    bus(1'b1, `TTCU_CMPB0, 32'h0000_0002);
    bus(1'b1, `TTCU_CTL0, 32'h0000_E003);
    span(1'b1);
    span(1'b0);
    chk(w, 8);
    span(1'b1);
    chk(w, 4);
    pins.gate0(1'b0);
    repeat (12) @(posedge clk);
    bus(1'b0, `TTCU_CNT0, 32'h0000_0000);
    v = r;
    repeat (20) @(posedge clk);
    rd(`TTCU_CNT0, v);
    bus(1'b1, `TTCU_CMPA1, 32'h0000_FFFF);
    bus(1'b1, `TTCU_CTL1, 32'h0000_C005);
    pins.burst1(5);
    repeat (12) @(posedge clk);
    rd(`TTCU_CNT1, 32'h0000_0005);
    bus(1'b1, `TTCU_CTL1, 32'h0000_C011);
    repeat (200) @(posedge clk);
    bus(1'b0, `TTCU_CNT1, 32'h0000_0000);
    chk(r > 32'h0000_0010, 1);
    pins.burst1(1);
    bus(1'b0, `TTCU_CNT1, 32'h0000_0000);
    chk(r < 32'h0000_0008, 1);
    bus(1'b1, `TTCU_CTL2, 32'h0000_C001);
    bus(1'b1, `TTCU_CTL1, 32'h0000_C009);
    bus(1'b1, `TTCU_CNT1, 32'h0000_0000);
    repeat (120) @(posedge clk);
    bus(1'b0, `TTCU_CNT1, 32'h0000_0000);
    chk(r >= 32'h0000_0009 && r <= 32'h0000_000D, 1);
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test;
  end
endmodule

// File: sim/ttcu_pins.sv
/*
  Model of the outside source on the two timer input pins.
  Assumes the bench calls its tasks just after a clock edge.
*/
`timescale 1ns/1ps
module ttcu_pins (
  // Clock
  input wire clk,
  // Timer input pins
  output logic in0,
  output logic in1
);
  initial begin
    in0 = 1'b0;
    in1 = 1'b0;
  end
  task automatic gate0(input logic v);
    @(posedge clk);
    in0 <= v;
  endtask
  // One edge in eight clocks, inside the quarter rate limit
  task automatic burst1(input int n);
    repeat (n) begin
      @(posedge clk);
      in1 <= 1'b1;
      repeat (4) @(posedge clk);
      in1 <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

// File: sim/ttcu_props.sv
/*
  Port checker for the triple timer unit.
  Assumes only the top ports; bound by the bind at the foot.
*/
`timescale 1ns/1ps
module ttcu_props (
  // Clock and reset
  input wire MCLK,
  input wire RSTN,
  // Bus replies
  input wire [31:0] HRDATA,
  input wire HREADYOUT,
  input wire HRESP,
  // Timer outputs
  input wire TMR_OUT0,
  input wire TMR_OUT1,
  input wire [2:0] TMR_IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // Outputs settle one edge into reset; check from the second
  logic rst_seen_q = 1'b0;
  always @(posedge MCLK) rst_seen_q <= !RSTN;
  // A timer is serviced once in four clocks
  sequence quiet0;
    !TMR_IRQ[0] [*3];
  endsequence
  sequence quiet2;
    !TMR_IRQ[2] [*3];
  endsequence
  ready_high_a: assert property (HREADYOUT)
    else $error("wait state seen");
  resp_okay_a: assert property (!HRESP)
    else $error("error response");
  irq_one_a: assert property ($onehot0(TMR_IRQ))
    else $error("two timers at once");
  irq0_pulse_a: assert property (TMR_IRQ[0] |=> quiet0)
    else $error("timer 0 request too close");
  irq2_pulse_a: assert property (TMR_IRQ[2] |=> quiet2)
    else $error("timer 2 request too close");
  out0_hold_a: assert property ($changed(TMR_OUT0) |=>
    $stable(TMR_OUT0) [*3]) else $error("output 0 too short");
  out1_hold_a: assert property ($changed(TMR_OUT1) |=>
    $stable(TMR_OUT1) [*3]) else $error("output 1 too short");
  rdata_wide_a: assert property (HRDATA[31:16] == 16'h0000)
    else $error("upper read bits set");
  reset_idle_a: assert property (disable iff (1'b0)
    !RSTN && rst_seen_q |-> TMR_OUT0 && TMR_OUT1 && TMR_IRQ == 3'h0)
    else $error("outputs busy in reset");
endmodule

bind ttcu_top ttcu_props u_props (.MCLK(MCLK), .RSTN(RSTN),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .TMR_OUT0(TMR_OUT0), .TMR_OUT1(TMR_OUT1), .TMR_IRQ(TMR_IRQ));
